/* File: verilog/flash_cfg_pkg.sv */
package flash_cfg_pkg;

  // command opcodes seen on the serial link
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_WRITE_STATUS  = 8'h01;
  localparam logic [7:0] OP_WRITE_FUNC    = 8'h42;
  localparam logic [7:0] OP_SET_READ_PAR  = 8'hC0;

  // read opcodes that pick a dummy count
  localparam logic [7:0] RD_NORMAL        = 8'h03;
  localparam logic [7:0] RD_FAST          = 8'h0B;
  localparam logic [7:0] RD_FAST_DTR      = 8'h0D;
  localparam logic [7:0] RD_DUAL_OUT      = 8'h3B;
  localparam logic [7:0] RD_QUAD_OUT      = 8'h6B;
  localparam logic [7:0] RD_DUAL_IO       = 8'hBB;
  localparam logic [7:0] RD_DUAL_IO_DTR   = 8'hBD;
  localparam logic [7:0] RD_QUAD_IO       = 8'hEB;
  localparam logic [7:0] RD_QUAD_IO_DTR   = 8'hED;

  // frame lengths in serial clock edges
  localparam logic [4:0] FRAME_CMD_ONLY   = 5'h08;
  localparam logic [4:0] FRAME_CMD_DATA   = 5'h10;
  localparam logic [4:0] FRAME_CNT_MAX    = 5'h1F;

  // status byte layout
  localparam int SR_LOCK_BIT              = 7;
  localparam int SR_QE_BIT                = 6;
  localparam int SR_LVL_HI                = 5;
  localparam int SR_LVL_LO                = 2;
  localparam int SR_WEL_BIT               = 1;
  localparam int SR_BUSY_BIT              = 0;
  localparam logic [7:0] SR_RESET         = 8'h00;

  // function byte layout
  localparam int FR_ROW_LOCK_LO           = 4;
  localparam int FR_ERASE_SUSPENDED_FLAG_BIT              = 3;
  localparam int FR_PROGRAM_SUSPENDED_FLAG_BIT              = 2;
  localparam int FR_TBS_BIT               = 1;
  localparam int FR_RSVD_BIT              = 0;
  localparam logic [7:0] FR_OTP_MASK      = 8'hF2;
  localparam logic [7:0] FR_RESET         = 8'h00;

  // read parameter byte layout
  localparam logic [7:0] RP_RESET         = 8'hE0;
  localparam int RP_DRV_HI                = 7;
  localparam int RP_DRV_LO                = 5;
  localparam int RP_DMY_HI                = 4;
  localparam int RP_DMY_LO                = 3;
  localparam int RP_WRAP_BIT              = 2;
  localparam int RP_BURST_HI              = 1;
  localparam logic [2:0] DRV_RSVD_A       = 3'h0;
  localparam logic [2:0] DRV_RSVD_B       = 3'h4;
  localparam logic [6:0] BURST_MIN_BYTES  = 7'h08;

  // dummy counts, indexed by the two dummy bits
  localparam logic [15:0] DMY_QUAD_TBL    = 16'hA846;
  localparam logic [15:0] DMY_DTR_TBL     = 16'h5423;
  localparam logic [15:0] DMY_DUAL_TBL    = 16'h8844;
  localparam logic [15:0] DMY_DDTR_TBL    = 16'h4422;
  localparam logic [3:0] DMY_FIXED_8      = 4'h8;
  localparam logic [3:0] DMY_FIXED_4      = 4'h4;
  localparam logic [3:0] DMY_NONE         = 4'h0;

  // memory shape
  localparam int BLOCK_ADDR_LO            = 16;
  localparam int BLOCK_IDX_W              = 7;

  typedef enum logic [1:0] {
    OP_PROGRAM  = 2'b00,
    OP_ERASE    = 2'b01,
    OP_CHIP_ERS = 2'b10,
    OP_ROW_PROG = 2'b11
  } op_kind_e;

endpackage

/* File: verilog/pin_sync.sv */
`timescale 1ns/1ns
module pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level_q
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // accept a change only once two late stages agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= RESET_VAL;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end

endmodule // pin_sync

/* File: verilog/protect_decode.sv */
`timescale 1ns/1ns
module protect_decode #(
  parameter int IDX_W = 7
) (
  input  wire logic [3:0]       level,
  input  wire logic             bottom,
  input  wire logic [IDX_W-1:0] block,
  output logic                  prot
);

  logic [IDX_W:0] count;
  logic [IDX_W:0] first_top;

  always_comb begin
    count     = (IDX_W+1)'(1) << (level[2:0] - 3'h1);
    first_top = (IDX_W+1)'(1 << IDX_W) - count;
    if (level[3]) begin
      prot = 1'b1;
    end else if (level[2:0] == 3'h0) begin
      prot = 1'b0;
    end else if (bottom) begin
      prot = {1'b0, block} < count;
    end else begin
      prot = {1'b0, block} >= first_top;
    end
  end

endmodule // protect_decode

/* File: verilog/flash_protect_and_read_config.sv */
`timescale 1ns/1ns
module flash_protect_and_read_config #(
  parameter int ADDR_W = 23
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        sck_pin,
  input  wire logic                        cs_n_pin,
  input  wire logic                        si_pin,
  input  wire logic                        wp_n_pin,
  input  wire logic                        hold_n_pin,
  input  wire logic                        op_valid,
  input  wire flash_cfg_pkg::op_kind_e     op_kind,
  input  wire logic [ADDR_W-1:0]           op_addr,
  input  wire logic [1:0]                  op_row,
  input  wire logic                        suspend_cmd,
  input  wire logic                        resume_cmd,
  input  wire logic                        program_active,
  input  wire logic                        erase_active,
  input  wire logic [7:0]                  read_opcode,
  input  wire logic                        read_four_wire,
  output logic [7:0]                       status_q,
  output logic [7:0]                       function_q,
  output logic [7:0]                       read_params_q,
  output logic                             wp_active_q,
  output logic                             hold_active_q,
  output logic                             quad_lines_q,
  output logic                             op_done_q,
  output logic                             op_allowed_q,
  output logic [3:0]                       dummy_cycles_q,
  output logic                             wrap_enable_q,
  output logic [6:0]                       burst_bytes_q,
  output logic                             drive_reserved_q
);

  logic                                    sck_s;
  logic                                    cs_n_s;
  logic                                    si_s;
  logic                                    wp_n_s;
  logic                                    hold_n_s;
  logic                                    sck_prev_q;
  logic                                    cs_prev_q;
  logic [15:0]                             shift_q;
  logic [4:0]                              cnt_q;
  logic                                    sck_rise;
  logic                                    frame_end;
  logic                                    cmd8;
  logic                                    cmd16;
  logic                                    hw_lock;
  logic                                    write_status_cmd_ok;
  logic                                    wrfr_ok;
  logic                                    srp_ok;
  logic                                    blk_prot;
  logic [flash_cfg_pkg::BLOCK_IDX_W-1:0]   blk_idx;
  logic [1:0]                              dmy_sel;

  pin_sync #(.RESET_VAL(1'b0)) u_sync_sck  (.clk(clk), .rst_n(rst_n), .pin(sck_pin),    .level_q(sck_s));
  pin_sync #(.RESET_VAL(1'b1)) u_sync_cs   (.clk(clk), .rst_n(rst_n), .pin(cs_n_pin),   .level_q(cs_n_s));
  pin_sync #(.RESET_VAL(1'b0)) u_sync_si   (.clk(clk), .rst_n(rst_n), .pin(si_pin),     .level_q(si_s));
  pin_sync #(.RESET_VAL(1'b1)) u_sync_wp   (.clk(clk), .rst_n(rst_n), .pin(wp_n_pin),   .level_q(wp_n_s));
  pin_sync #(.RESET_VAL(1'b1)) u_sync_hold (.clk(clk), .rst_n(rst_n), .pin(hold_n_pin), .level_q(hold_n_s));

  // serial framing: mode 0, data sampled on rising sck
  assign sck_rise  = sck_s & ~sck_prev_q;
  assign frame_end = cs_n_s & ~cs_prev_q;
  assign cmd8      = frame_end && (cnt_q == flash_cfg_pkg::FRAME_CMD_ONLY);
  assign cmd16     = frame_end && (cnt_q == flash_cfg_pkg::FRAME_CMD_DATA);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
    end else begin
      sck_prev_q <= sck_s;
      cs_prev_q  <= cs_n_s;
    end
  end

  // counter saturates so over-long frames are never mistaken for valid ones
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= 16'h0000;
      cnt_q   <= 5'h00;
    end else if (frame_end || cs_n_s) begin
      cnt_q   <= 5'h00;
    end else if (sck_rise) begin
      shift_q <= {shift_q[14:0], si_s};
      if (cnt_q != flash_cfg_pkg::FRAME_CNT_MAX) begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  // write-protect only means something while the pin is not a data line
  assign hw_lock = status_q[flash_cfg_pkg::SR_LOCK_BIT] & wp_active_q;
  assign write_status_cmd_ok = cmd16 && (shift_q[15:8] == flash_cfg_pkg::OP_WRITE_STATUS)
                   && status_q[flash_cfg_pkg::SR_WEL_BIT] && !hw_lock;
  assign wrfr_ok = cmd16 && (shift_q[15:8] == flash_cfg_pkg::OP_WRITE_FUNC)
                   && status_q[flash_cfg_pkg::SR_WEL_BIT];
  assign srp_ok  = cmd16 && (shift_q[15:8] == flash_cfg_pkg::OP_SET_READ_PAR);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= flash_cfg_pkg::SR_RESET;
    end else begin
      if (write_status_cmd_ok) begin
        status_q[flash_cfg_pkg::SR_LOCK_BIT:flash_cfg_pkg::SR_LVL_LO] <=
          shift_q[flash_cfg_pkg::SR_LOCK_BIT:flash_cfg_pkg::SR_LVL_LO];
      end
      if (cmd8 && shift_q[7:0] == flash_cfg_pkg::OP_WRITE_ENABLE) begin
        status_q[flash_cfg_pkg::SR_WEL_BIT] <= 1'b1;
      end else if ((cmd8 && shift_q[7:0] == flash_cfg_pkg::OP_WRITE_DISABLE) || write_status_cmd_ok || wrfr_ok) begin
        status_q[flash_cfg_pkg::SR_WEL_BIT] <= 1'b0;
      end
      status_q[flash_cfg_pkg::SR_BUSY_BIT] <= 1'b0;
    end
  end

  // function byte: one-time bits only ever OR in, suspend flags set over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      function_q <= flash_cfg_pkg::FR_RESET;
    end else begin
      if (wrfr_ok) begin
        function_q[7:flash_cfg_pkg::FR_ROW_LOCK_LO] <= function_q[7:flash_cfg_pkg::FR_ROW_LOCK_LO]
          | shift_q[7:flash_cfg_pkg::FR_ROW_LOCK_LO];
        function_q[flash_cfg_pkg::FR_TBS_BIT] <= function_q[flash_cfg_pkg::FR_TBS_BIT]
          | shift_q[flash_cfg_pkg::FR_TBS_BIT];
      end
      if (suspend_cmd && program_active) begin
        function_q[flash_cfg_pkg::FR_PROGRAM_SUSPENDED_FLAG_BIT] <= 1'b1;
      end else if (resume_cmd) begin
        function_q[flash_cfg_pkg::FR_PROGRAM_SUSPENDED_FLAG_BIT] <= 1'b0;
      end
      if (suspend_cmd && erase_active) begin
        function_q[flash_cfg_pkg::FR_ERASE_SUSPENDED_FLAG_BIT] <= 1'b1;
      end else if (resume_cmd) begin
        function_q[flash_cfg_pkg::FR_ERASE_SUSPENDED_FLAG_BIT] <= 1'b0;
      end
      function_q[flash_cfg_pkg::FR_RSVD_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      read_params_q <= flash_cfg_pkg::RP_RESET;
    end else if (srp_ok) begin
      read_params_q <= shift_q[7:0];
    end
  end

  // pin roles follow quad-enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_active_q   <= 1'b0;
      hold_active_q <= 1'b0;
      quad_lines_q  <= 1'b0;
    end else begin
      wp_active_q   <= !status_q[flash_cfg_pkg::SR_QE_BIT] && !wp_n_s;
      hold_active_q <= !status_q[flash_cfg_pkg::SR_QE_BIT] && !hold_n_s;
      quad_lines_q  <= status_q[flash_cfg_pkg::SR_QE_BIT];
    end
  end

  assign blk_idx = op_addr[flash_cfg_pkg::BLOCK_ADDR_LO +: flash_cfg_pkg::BLOCK_IDX_W];

  protect_decode #(.IDX_W(flash_cfg_pkg::BLOCK_IDX_W)) u_prot (
    .level  (status_q[flash_cfg_pkg::SR_LVL_HI:flash_cfg_pkg::SR_LVL_LO]),
    .bottom (function_q[flash_cfg_pkg::FR_TBS_BIT]),
    .block  (blk_idx),
    .prot   (blk_prot)
  );

  // one verdict per request, a cycle later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_done_q    <= 1'b0;
      op_allowed_q <= 1'b0;
    end else begin
      op_done_q <= op_valid;
      case (op_kind)
        flash_cfg_pkg::OP_PROGRAM,
        flash_cfg_pkg::OP_ERASE: begin
          op_allowed_q <= op_valid && !blk_prot;
        end
        flash_cfg_pkg::OP_CHIP_ERS: begin
          op_allowed_q <= op_valid
            && (status_q[flash_cfg_pkg::SR_LVL_HI:flash_cfg_pkg::SR_LVL_LO] == 4'h0);
        end
        flash_cfg_pkg::OP_ROW_PROG: begin
          op_allowed_q <= op_valid && !function_q[flash_cfg_pkg::FR_ROW_LOCK_LO + 32'(op_row)];
        end
        default: begin
          op_allowed_q <= 1'b0;
        end
      endcase
    end
  end

  // counts already cover the mode-bit cycles, nothing is added
  assign dmy_sel = read_params_q[flash_cfg_pkg::RP_DMY_HI:flash_cfg_pkg::RP_DMY_LO];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dummy_cycles_q <= flash_cfg_pkg::DMY_NONE;
    end else begin
      case (read_opcode)
        flash_cfg_pkg::RD_QUAD_IO: begin
          dummy_cycles_q <= flash_cfg_pkg::DMY_QUAD_TBL[dmy_sel*4 +: 4];
        end
        flash_cfg_pkg::RD_FAST: begin
          dummy_cycles_q <= read_four_wire ? flash_cfg_pkg::DMY_QUAD_TBL[dmy_sel*4 +: 4]
                                           : flash_cfg_pkg::DMY_FIXED_8;
        end
        flash_cfg_pkg::RD_QUAD_IO_DTR: begin
          dummy_cycles_q <= flash_cfg_pkg::DMY_DTR_TBL[dmy_sel*4 +: 4];
        end
        flash_cfg_pkg::RD_FAST_DTR: begin
          dummy_cycles_q <= read_four_wire ? flash_cfg_pkg::DMY_DTR_TBL[dmy_sel*4 +: 4]
                                           : flash_cfg_pkg::DMY_FIXED_4;
        end
        flash_cfg_pkg::RD_DUAL_IO: begin
          dummy_cycles_q <= flash_cfg_pkg::DMY_DUAL_TBL[dmy_sel*4 +: 4];
        end
        flash_cfg_pkg::RD_DUAL_IO_DTR: begin
          dummy_cycles_q <= flash_cfg_pkg::DMY_DDTR_TBL[dmy_sel*4 +: 4];
        end
        flash_cfg_pkg::RD_DUAL_OUT,
        flash_cfg_pkg::RD_QUAD_OUT: begin
          dummy_cycles_q <= flash_cfg_pkg::DMY_FIXED_8;
        end
        default: begin
          dummy_cycles_q <= flash_cfg_pkg::DMY_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrap_enable_q    <= 1'b0;
      burst_bytes_q    <= flash_cfg_pkg::BURST_MIN_BYTES;
      drive_reserved_q <= 1'b0;
    end else begin
      wrap_enable_q    <= read_params_q[flash_cfg_pkg::RP_WRAP_BIT];
      burst_bytes_q    <= flash_cfg_pkg::BURST_MIN_BYTES
                          << read_params_q[flash_cfg_pkg::RP_BURST_HI:0];
      drive_reserved_q <= (read_params_q[flash_cfg_pkg::RP_DRV_HI:flash_cfg_pkg::RP_DRV_LO]
                             == flash_cfg_pkg::DRV_RSVD_A)
                          || (read_params_q[flash_cfg_pkg::RP_DRV_HI:flash_cfg_pkg::RP_DRV_LO]
                             == flash_cfg_pkg::DRV_RSVD_B);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_block_refuse: assert property (op_valid && op_kind inside {flash_cfg_pkg::OP_PROGRAM,
      flash_cfg_pkg::OP_ERASE} && blk_prot |=> op_done_q && !op_allowed_q)
    else $error("protected block access granted");
  chk_chip_erase_gate: assert property (op_valid && op_kind == flash_cfg_pkg::OP_CHIP_ERS
      |=> op_allowed_q == ($past(status_q[5:2]) == 4'h0))
    else $error("chip erase verdict wrong");
  chk_status_frozen: assert property (hw_lock |=> $stable(status_q[7:2]))
    else $error("locked status bits changed");
  chk_status_write: assert property (write_status_cmd_ok |=> status_q[7:2] == $past(shift_q[7:2]))
    else $error("status write not applied");
  chk_all_blocks: assert property (op_valid && status_q[5] && op_kind inside {flash_cfg_pkg::OP_PROGRAM,
      flash_cfg_pkg::OP_ERASE} |=> !op_allowed_q)
    else $error("full protect leaked");
  chk_tbs_sticky: assert property (function_q[1] |=> function_q[1])
    else $error("top bottom select returned");
  chk_otp_sticky: assert property ((function_q[7:4] & ~$past(function_q[7:4])) == 4'h0 ||
      $past(wrfr_ok))
    else $error("row lock bit changed without write");
  chk_otp_hold: assert property (($past(function_q) & ~function_q & flash_cfg_pkg::FR_OTP_MASK) == 8'h00)
    else $error("one time bit cleared");
  chk_row_lock: assert property (op_valid && op_kind == flash_cfg_pkg::OP_ROW_PROG &&
      function_q[4 + 32'(op_row)] |=> !op_allowed_q)
    else $error("locked row programmed");
  chk_program_suspended_flag_set: assert property (suspend_cmd && program_active |=> function_q[2] [*2] or
      (function_q[2] ##1 $past(resume_cmd)))
    else $error("program suspend flag missing");
  chk_erase_suspended_flag_set: assert property (suspend_cmd && erase_active |=> function_q[3])
    else $error("erase suspend flag missing");
  chk_rp_load: assert property (srp_ok |=> read_params_q == $past(shift_q[7:0]))
    else $error("read parameters not loaded");
  chk_fixed_dummy: assert property (read_opcode == flash_cfg_pkg::RD_DUAL_OUT
      |=> dummy_cycles_q == 4'h8)
    else $error("dual output dummy count wrong");

endmodule // flash_protect_and_read_config

/* File: verif/host_link_model.sv */
`timescale 1ns/1ns
module host_link_model (
  output logic sck,
  output logic cs_n,
  output logic si
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // mode 0: clock rests low outside frames
  task automatic shift(input logic [15:0] v, input int n);
    cs_n = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      si = v[i];
      #62 sck = 1'b1;
      #63 sck = 1'b0;
    end
    #62 cs_n = 1'b1;
    si = ~si; // released line must not show a stale bit
    #200;
  endtask
  task automatic cmd16(input logic [7:0] op, input logic [7:0] d);
    shift({op, d}, 16);
  endtask
endmodule // host_link_model

/* File: verif/tb.sv */
`timescale 1ns/1ns
module tb;
  logic       clk, rst_n, sck, cs_n, si, wp_n, hold_n, op_valid, suspend, resume, p_act, e_act, fw;
  logic       wp_act, hold_act, quad, done, allowed, wrap, drv_rsvd;
  logic [7:0] status, func, rpar, opc;
  logic [3:0] dummy;
  logic [6:0] burst;
  logic [22:0] addr;
  logic [1:0] row;
  logic [2:0] drv;
  flash_cfg_pkg::op_kind_e kind;
  int failures, comparisons, cycles;
  logic [24:0] rows [13] = '{{8'h03, 1'b0, 16'h0000}, {8'h0B, 1'b0, 16'h8888}, {8'h0B, 1'b1, 16'hA846},
    {8'h0D, 1'b0, 16'h4444}, {8'h0D, 1'b1, 16'h5423}, {8'h3B, 1'b0, 16'h8888}, {8'h6B, 1'b0, 16'h8888},
    {8'hBB, 1'b0, 16'h8844}, {8'hBD, 1'b0, 16'h4422}, {8'hEB, 1'b0, 16'hA846}, {8'hEB, 1'b1, 16'hA846},
    {8'hED, 1'b0, 16'h5423}, {8'hED, 1'b1, 16'h5423}};
  logic [2:0] drv_codes [4] = '{3'h7, 3'h4, 3'h5, 3'h0};
  host_link_model host_u (.sck(sck), .cs_n(cs_n), .si(si));
  flash_protect_and_read_config dut_u (.clk(clk), .rst_n(rst_n), .sck_pin(sck), .cs_n_pin(cs_n), .si_pin(si),
    .wp_n_pin(wp_n), .hold_n_pin(hold_n), .op_valid(op_valid), .op_kind(kind), .op_addr(addr), .op_row(row),
    .suspend_cmd(suspend), .resume_cmd(resume), .program_active(p_act), .erase_active(e_act),
    .read_opcode(opc), .read_four_wire(fw), .status_q(status), .function_q(func), .read_params_q(rpar),
    .wp_active_q(wp_act), .hold_active_q(hold_act), .quad_lines_q(quad), .op_done_q(done),
    .op_allowed_q(allowed), .dummy_cycles_q(dummy), .wrap_enable_q(wrap), .burst_bytes_q(burst),
    .drive_reserved_q(drv_rsvd));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      complete_run();
    end
  end
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic verdict(flash_cfg_pkg::op_kind_e k, logic [6:0] blk, logic [1:0] r, logic exp);
    @(negedge clk);
    op_valid = 1'b1;
    kind = k;
    addr = {blk, 16'h0000};
    row = r;
    @(negedge clk);
    op_valid = 1'b0;
    check("op_done_q", {7'h00, done}, 8'h01);
    check("op_allowed_q", {7'h00, allowed}, {7'h00, exp});
  endtask
  // every status or function write needs the enable latch first
  task automatic wreg(logic [7:0] op, logic [7:0] d);
    host_u.shift(16'h0600, 8);
    host_u.cmd16(op, d);
    // link frames end off the clock grid; look only at a falling edge
    @(negedge clk);
  endtask
  task automatic pins(logic w, logic h);
    @(negedge clk);
    wp_n = w;
    hold_n = h;
    repeat (6) @(negedge clk);
  endtask
  task automatic pulse(logic p, logic e, logic [7:0] exp);
    @(negedge clk);
    p_act = p;
    e_act = e;
    suspend = 1'b1;
    @(negedge clk);
    suspend = 1'b0;
    @(negedge clk);
    check("function_q", func, exp);
    resume = 1'b1;
    @(negedge clk);
    resume = 1'b0;
    @(negedge clk);
    check("function_q", func, 8'h12);
  endtask
  task automatic complete_run;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {rst_n, op_valid, suspend, resume, p_act, e_act, fw, row, addr, opc} = '0;
    {wp_n, hold_n} = 2'b11;
    kind = flash_cfg_pkg::OP_PROGRAM;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    check("status_q", status, 8'h00);
    check("function_q", func, 8'h00);
    check("read_params_q", rpar, 8'hE0);
    check("wrap_enable_q", {7'h00, wrap}, 8'h00);
    check("burst_bytes_q", {1'b0, burst}, 8'h08);
    check("drive_reserved_q", {7'h00, drv_rsvd}, 8'h00);
    $display("test reset done");
    for (int d = 0; d < 4; d++) begin
      drv = drv_codes[d];
      host_u.cmd16(8'hC0, {drv, d[1:0], 1'b1, d[1:0]});
      @(negedge clk);
      check("read_params_q", rpar, {drv, d[1:0], 1'b1, d[1:0]});
      check("burst_bytes_q", {1'b0, burst}, 8'h08 << d);
      check("wrap_enable_q", {7'h00, wrap}, 8'h01);
      check("drive_reserved_q", {7'h00, drv_rsvd}, {7'h00, drv[1:0] == 2'h0});
      for (int r = 0; r < 13; r++) begin
        @(negedge clk);
        opc = rows[r][24:17];
        fw = rows[r][16];
        repeat (2) @(negedge clk);
        check("dummy_cycles_q", {4'h0, dummy}, {4'h0, rows[r][4*d +: 4]});
      end
    end
    $display("test read parameters done");
    wreg(8'h01, 8'h0C);
    check("status_q", {status[7:2], 2'b00}, 8'h0C);
    verdict(flash_cfg_pkg::OP_ERASE, 7'h7C, 2'h0, 1'b0);
    verdict(flash_cfg_pkg::OP_PROGRAM, 7'h7B, 2'h0, 1'b1);
    verdict(flash_cfg_pkg::OP_CHIP_ERS, 7'h00, 2'h0, 1'b0);
    wreg(8'h42, 8'h13);
    check("function_q", func, 8'h12);
    verdict(flash_cfg_pkg::OP_ERASE, 7'h03, 2'h0, 1'b0);
    verdict(flash_cfg_pkg::OP_PROGRAM, 7'h04, 2'h0, 1'b1);
    verdict(flash_cfg_pkg::OP_ROW_PROG, 7'h00, 2'h0, 1'b0);
    verdict(flash_cfg_pkg::OP_ROW_PROG, 7'h00, 2'h1, 1'b1);
    wreg(8'h42, 8'h00);
    check("function_q", func, 8'h12);
    wreg(8'h01, 8'h24);
    verdict(flash_cfg_pkg::OP_PROGRAM, 7'h40, 2'h0, 1'b0);
    verdict(flash_cfg_pkg::OP_ERASE, 7'h00, 2'h0, 1'b0);
    pulse(1'b1, 1'b0, 8'h16);
    pulse(1'b0, 1'b1, 8'h1A);
    $display("test protection done");
    wreg(8'h01, 8'h80);
    pins(1'b0, 1'b0);
    check("wp_active_q", {6'h00, wp_act, hold_act}, 8'h03);
    wreg(8'h01, 8'h04);
    check("status_q", {status[7:2], 2'b00}, 8'h80);
    verdict(flash_cfg_pkg::OP_CHIP_ERS, 7'h00, 2'h0, 1'b1);
    pins(1'b1, 1'b1);
    wreg(8'h01, 8'h40);
    check("status_q", {status[7:2], 2'b00}, 8'h40);
    pins(1'b0, 1'b0);
    check("quad_lines_q", {5'h00, quad, wp_act, hold_act}, 8'h04);
    $display("test lock done");
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    check("read_params_q", rpar, 8'hE0);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    check("status_q", status, 8'h00);
    check("function_q", func, 8'h00);
    check("read_params_q", rpar, 8'hE0);
    $display("test second reset done");
    complete_run();
  end
endmodule // tb
